/* File: verilog/tmcr_timer_regs.vh */
// constants of the timer/counter with match and capture registers
// included by every design file of the block; definitions only
`ifndef TMCR_TIMER_REGS_VH
`define TMCR_TIMER_REGS_VH

// register indices; byte address on the bus is four times the index
`define TMCR_IDX_TIMER_CONTROL 16'hfe10
`define TMCR_IDX_PRESCALER_MATCH 16'hfe11
`define TMCR_IDX_COUNT_LOW_BYTE 16'hfe12
`define TMCR_IDX_COUNT_HIGH_BYTE 16'hfe13
`define TMCR_IDX_MATCH_DATA_LOW 16'hfe14
`define TMCR_IDX_MATCH_DATA_HIGH 16'hfe15
`define TMCR_IDX_CAPTURE_LOW_BYTE 16'hfe16
`define TMCR_IDX_CAPTURE_HIGH_BYTE 16'hfe17

// apb address width, enough for the byte address of the indices
`define TMCR_ADDR_W 18

// field positions of timer_control
`define TMCR_BIT_HIGH_RUN 7
`define TMCR_BIT_LOW_RUN 6
`define TMCR_BIT_LENGTH_SELECT 5
`define TMCR_BIT_LOW_EXT_CLOCK_SELECT 4
`define TMCR_BIT_HIGH_MATCH_FLAG 3
`define TMCR_BIT_HIGH_IRQ_ENABLE 2
`define TMCR_BIT_LOW_MATCH_FLAG 1
`define TMCR_BIT_LOW_IRQ_ENABLE 0

// reset values
`define TMCR_RST_TIMER_CONTROL 8'h00
`define TMCR_RST_PRESCALER_MATCH 8'h00
`define TMCR_RST_COUNT 8'h00
`define TMCR_RST_MATCH_DATA 8'h00
`define TMCR_RST_CAPTURE 8'h00

// highest count of one byte, where a low byte carries
`define TMCR_BYTE_MAX 8'hff

`endif

/* File: verilog/tmcr_prescaler.v */
// programmable prescaler: divides the cycle clock by match value plus one
// assumes clk_i is the cycle clock and hold_i the system hold state
`timescale 1ns/100ps
`include "tmcr_timer_regs.vh"

module tmcr_prescaler #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire clk_i,
    input wire resetn_i,
    // control
    input wire hold_i,
    input wire restart_i,
    input wire [WIDTH-1:0] match_value_i,
    // output event
    output wire tick_o
);

    reg [WIDTH-1:0] count; // cycle clocks since last match
    reg [WIDTH-1:0] next_count; // value for the next edge

    // one pulse per match_value_i plus one cycles, none in hold
    assign tick_o = !hold_i && (count == match_value_i);

    // next count: write restarts, match restarts, hold freezes
    always @* begin
        if (restart_i) begin
            next_count = {WIDTH{1'b0}};
        end else if (hold_i) begin
            next_count = count;
        end else if (tick_o) begin
            next_count = {WIDTH{1'b0}};
        end else begin
            next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // count register
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count <= {WIDTH{1'b0}};
        end else begin
            count <= next_count;
        end
    end

endmodule

/* File: verilog/tmcr_byte_counter.v */
// one counter byte with its match buffer
// assumes the caller forms the tick and the match pulse
`timescale 1ns/100ps
`include "tmcr_timer_regs.vh"

module tmcr_byte_counter #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire clk_i,
    input wire resetn_i,
    // control
    input wire run_i,
    input wire tick_i,
    input wire match_i,
    input wire [WIDTH-1:0] match_data_i,
    // state
    output reg [WIDTH-1:0] count_o,
    output reg [WIDTH-1:0] match_buffer_o
);

    // count and buffer update
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_o <= {WIDTH{1'b0}};
            match_buffer_o <= {WIDTH{1'b0}};
        end else if (!run_i) begin
            // stopped: held at zero, buffer follows data
            count_o <= {WIDTH{1'b0}};
            match_buffer_o <= match_data_i;
        end else if (match_i) begin
            // match: back to zero, buffer reloaded
            count_o <= {WIDTH{1'b0}};
            match_buffer_o <= match_data_i;
        end else if (tick_i) begin
            count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule

/* File: verilog/tmcr_timer.v */
// timer/counter 0: prescaler, two counter bytes, match flags, captures
// assumes an apb master on clk_i; event and capture inputs are one
// cycle pulses already edge detected and pin selected upstream
`timescale 1ns/100ps
`include "tmcr_timer_regs.vh"

module tmcr_timer #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire clk_i,
    input wire resetn_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [`TMCR_ADDR_W-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output wire pready_o,
    output reg [31:0] prdata_o,
    output reg pslverr_o,
    // system state and event inputs
    input wire hold_i,
    input wire ext_event_i,
    input wire capture_low_i,
    input wire capture_high_i,
    // interrupt requests
    output wire irq_low_o,
    output wire irq_high_o
);

    // ------------------------------------------------------------
    // software visible registers
    // ------------------------------------------------------------
    reg high_run; // high byte runs
    reg low_run; // low byte runs
    reg length_select; // 1: one 16-bit counter
    reg low_ext_clock_select; // 1: low byte counts external events
    reg high_match_flag; // sticky high match
    reg high_irq_enable; // high request enable
    reg low_match_flag; // sticky low match
    reg low_irq_enable; // low request enable
    reg [WIDTH-1:0] prescaler_match; // prescaler match value
    reg [WIDTH-1:0] match_data_low; // low match data
    reg [WIDTH-1:0] match_data_high; // high match data
    reg [WIDTH-1:0] capture_low_byte; // captured low count
    reg [WIDTH-1:0] capture_high_byte; // captured high count

    // ------------------------------------------------------------
    // internal nets
    // ------------------------------------------------------------
    wire [WIDTH-1:0] count_low_byte; // low counter value
    wire [WIDTH-1:0] count_high_byte; // high counter value
    wire [WIDTH-1:0] buffer_low; // low match buffer
    wire [WIDTH-1:0] buffer_high; // high match buffer
    wire prescaler_tick; // prescaler match pulse
    wire low_tick; // low byte count clock
    wire high_tick; // high byte count clock
    wire low_carry; // low byte wraps in 16-bit mode
    wire low_equal; // low count equals its buffer
    wire high_equal; // high count equals its buffer
    wire wide_match; // 16-bit match pulse
    wire low_match; // low match signal
    wire high_match; // high match signal
    wire [15:0] word_index; // word index of the access
    wire setup; // apb setup cycle
    wire access; // apb access cycle
    wire write_en; // write takes effect now
    wire prescaler_write; // write to prescaler_match
    wire control_write; // write to timer_control
    reg mapped; // index hits a register
    reg [WIDTH-1:0] read_value; // data of addressed register
    wire [WIDTH-1:0] control_value; // timer_control as read

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------

    // word index from the byte address
    assign word_index = paddr_i[17:2];

    // phases of a transfer
    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i;

    // zero wait states: every access completes at once
    assign pready_o = 1'b1;

    // writes only through lane 0, where the 8-bit data sits
    assign write_en = access && pwrite_i && pstrb_i[0] && mapped;

    // per register write strobes
    assign control_write = write_en &&
        (word_index == `TMCR_IDX_TIMER_CONTROL);
    assign prescaler_write = write_en &&
        (word_index == `TMCR_IDX_PRESCALER_MATCH);

    // timer_control as software reads it
    assign control_value = {high_run, low_run, length_select,
        low_ext_clock_select, high_match_flag, high_irq_enable,
        low_match_flag, low_irq_enable};

    // read mux and map check
    always @* begin
        mapped = 1'b1;
        read_value = {WIDTH{1'b0}};
        case (word_index)
            `TMCR_IDX_TIMER_CONTROL: begin
                read_value = control_value;
            end
            `TMCR_IDX_PRESCALER_MATCH: begin
                read_value = prescaler_match;
            end
            `TMCR_IDX_COUNT_LOW_BYTE: begin
                read_value = count_low_byte;
            end
            `TMCR_IDX_COUNT_HIGH_BYTE: begin
                read_value = count_high_byte;
            end
            `TMCR_IDX_MATCH_DATA_LOW: begin
                read_value = match_data_low;
            end
            `TMCR_IDX_MATCH_DATA_HIGH: begin
                read_value = match_data_high;
            end
            `TMCR_IDX_CAPTURE_LOW_BYTE: begin
                read_value = capture_low_byte;
            end
            `TMCR_IDX_CAPTURE_HIGH_BYTE: begin
                read_value = capture_high_byte;
            end
            default: begin
                // unmapped: reads zero, answers with an error
                mapped = 1'b0;
            end
        endcase
    end

    // read data and error captured in the setup cycle
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (setup) begin
            // writes return zero data
            prdata_o <= pwrite_i ? 32'h0000_0000 :
                {{(32-WIDTH){1'b0}}, read_value};
            pslverr_o <= !mapped;
        end
    end

    // ------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------

    // timer_control, prescaler and match data registers
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            high_run <= 1'b0;
            low_run <= 1'b0;
            length_select <= 1'b0;
            low_ext_clock_select <= 1'b0;
            high_irq_enable <= 1'b0;
            low_irq_enable <= 1'b0;
            prescaler_match <= `TMCR_RST_PRESCALER_MATCH;
            match_data_low <= `TMCR_RST_MATCH_DATA;
            match_data_high <= `TMCR_RST_MATCH_DATA;
        end else if (write_en) begin
            case (word_index)
                `TMCR_IDX_TIMER_CONTROL: begin
                    high_run <= pwdata_i[`TMCR_BIT_HIGH_RUN];
                    low_run <= pwdata_i[`TMCR_BIT_LOW_RUN];
                    length_select <=
                        pwdata_i[`TMCR_BIT_LENGTH_SELECT];
                    low_ext_clock_select <=
                        pwdata_i[`TMCR_BIT_LOW_EXT_CLOCK_SELECT];
                    high_irq_enable <=
                        pwdata_i[`TMCR_BIT_HIGH_IRQ_ENABLE];
                    low_irq_enable <=
                        pwdata_i[`TMCR_BIT_LOW_IRQ_ENABLE];
                end
                `TMCR_IDX_PRESCALER_MATCH: begin
                    prescaler_match <= pwdata_i[WIDTH-1:0];
                end
                `TMCR_IDX_MATCH_DATA_LOW: begin
                    match_data_low <= pwdata_i[WIDTH-1:0];
                end
                `TMCR_IDX_MATCH_DATA_HIGH: begin
                    match_data_high <= pwdata_i[WIDTH-1:0];
                end
                default: begin
                    // counters and captures ignore writes
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // match flags
    // ------------------------------------------------------------

    // sticky flags: a match beats a clearing write in the same cycle;
    // writing 1 leaves a flag as it is, writing 0 clears it
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            high_match_flag <= 1'b0;
            low_match_flag <= 1'b0;
        end else begin
            if (high_match) begin
                high_match_flag <= 1'b1;
            end else if (control_write &&
                !pwdata_i[`TMCR_BIT_HIGH_MATCH_FLAG]) begin
                high_match_flag <= 1'b0;
            end
            if (low_match) begin
                low_match_flag <= 1'b1;
            end else if (control_write &&
                !pwdata_i[`TMCR_BIT_LOW_MATCH_FLAG]) begin
                low_match_flag <= 1'b0;
            end
        end
    end

    // interrupt requests as levels
    assign irq_high_o = high_irq_enable && high_match_flag;
    assign irq_low_o = low_irq_enable && low_match_flag;

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------

    // cycle clock divider, restarted by any prescaler write
    tmcr_prescaler #(
        .WIDTH(WIDTH)
    ) u_prescaler (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .hold_i(hold_i),
        .restart_i(prescaler_write),
        .match_value_i(prescaler_match),
        .tick_o(prescaler_tick)
    );

    // ------------------------------------------------------------
    // count clocks and match signals
    // ------------------------------------------------------------

    // low clock: prescaler or one-cycle external event pulse
    assign low_tick = low_ext_clock_select ?
        ext_event_i : prescaler_tick;

    // byte compares against the match buffers
    assign low_equal = (count_low_byte == buffer_low);
    assign high_equal = (count_high_byte == buffer_high);

    // 16-bit match needs all sixteen bits on a low count clock
    assign wide_match = length_select && low_run && low_tick &&
        low_equal && high_equal;

    // low byte wraps into the high byte in 16-bit mode
    assign low_carry = low_tick && low_run &&
        (count_low_byte == `TMCR_BYTE_MAX) && !wide_match;

    // high clock: prescaler alone, or low carries when 16-bit
    assign high_tick = length_select ?
        low_carry : prescaler_tick;

    // match signals; in 16-bit mode both come from the wide compare
    assign low_match = length_select ? wide_match :
        (low_run && low_tick && low_equal);
    assign high_match = length_select ? (wide_match && high_run) :
        (high_run && high_tick && high_equal);

    // ------------------------------------------------------------
    // counter bytes
    // ------------------------------------------------------------

    // low counter and buffer
    tmcr_byte_counter #(
        .WIDTH(WIDTH)
    ) u_low (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .run_i(low_run),
        .tick_i(low_tick),
        .match_i(low_match),
        .match_data_i(match_data_low),
        .count_o(count_low_byte),
        .match_buffer_o(buffer_low)
    );

    // high counter and buffer
    tmcr_byte_counter #(
        .WIDTH(WIDTH)
    ) u_high (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .run_i(high_run),
        .tick_i(high_tick),
        .match_i(high_match),
        .match_data_i(match_data_high),
        .count_o(count_high_byte),
        .match_buffer_o(buffer_high)
    );

    // ------------------------------------------------------------
    // capture registers
    // ------------------------------------------------------------

    // captures take the counter value before this edge's update
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            capture_low_byte <= `TMCR_RST_CAPTURE;
            capture_high_byte <= `TMCR_RST_CAPTURE;
        end else begin
            // low: own trigger, or high trigger in 16-bit mode
            if (length_select ? capture_high_i : capture_low_i) begin
                capture_low_byte <= count_low_byte;
            end
            // high: always its own trigger
            if (capture_high_i) begin
                capture_high_byte <= count_high_byte;
            end
        end
    end

endmodule

/* File: verif/tmcr_timer_asserts.sv */
// checker for the timer register block: bus and request port relations
// assumes it is bound to tmcr_timer and sees only that module's ports
`timescale 1ns/100ps
`include "tmcr_timer_regs.vh"

module tmcr_timer_asserts (
    // clock and reset
    input wire clk_i,
    input wire resetn_i,
    // apb slave side
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [`TMCR_ADDR_W-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    input wire pready_o,
    input wire [31:0] prdata_o,
    input wire pslverr_o,
    // system state and events
    input wire hold_i,
    input wire ext_event_i,
    input wire capture_low_i,
    input wire capture_high_i,
    // requests
    input wire irq_low_o,
    input wire irq_high_o
);
    // decoded bus events
    wire [15:0] idx = paddr_i[`TMCR_ADDR_W-1:2];
    wire setup = psel_i && !penable_i;
    wire acc_wr = psel_i && penable_i && pwrite_i && pready_o && pstrb_i[0];
    wire ctl_wr = acc_wr && idx == `TMCR_IDX_TIMER_CONTROL;
    wire rd_cnl = setup && !pwrite_i && idx == `TMCR_IDX_COUNT_LOW_BYTE;
    wire rd_cnh = setup && !pwrite_i && idx == `TMCR_IDX_COUNT_HIGH_BYTE;
    wire bad = idx < `TMCR_IDX_TIMER_CONTROL ||
        idx > `TMCR_IDX_CAPTURE_HIGH_BYTE;
    reg low_run; // run bits as software last wrote them
    reg high_run;

    // shadow of the run bits
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_run <= 1'b0;
            high_run <= 1'b0;
        end else if (ctl_wr) begin
            low_run <= pwdata_i[`TMCR_BIT_LOW_RUN];
            high_run <= pwdata_i[`TMCR_BIT_HIGH_RUN];
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    low_sticky_a: assert property (irq_low_o && !ctl_wr |=> irq_low_o)
        else $error("low request dropped without control write");
    high_sticky_a: assert property (
        irq_high_o && !ctl_wr |=> irq_high_o)
        else $error("high request dropped without control write");
    low_irq_off_a: assert property (
        ctl_wr && !pwdata_i[0] |=> !irq_low_o)
        else $error("low request with enable cleared");
    high_irq_off_a: assert property (
        ctl_wr && !pwdata_i[2] |=> !irq_high_o)
        else $error("high request with enable cleared");
    low_rise_cause_a: assert property ($rose(irq_low_o) |->
        $past(ctl_wr) || $past(low_run))
        else $error("low request rose while low byte stopped");
    high_rise_cause_a: assert property ($rose(irq_high_o) |->
        $past(ctl_wr) || $past(high_run))
        else $error("high request rose while high byte stopped");
    low_stop_zero_a: assert property (rd_cnl && !low_run &&
        !$past(low_run) && !$past(low_run, 2) |=> prdata_o == 32'h0)
        else $error("stopped low count not zero");
    high_stop_zero_a: assert property (rd_cnh && !high_run &&
        !$past(high_run) && !$past(high_run, 2) |=> prdata_o == 32'h0)
        else $error("stopped high count not zero");
    bad_addr_err_a: assert property (setup |=> pslverr_o == $past(bad))
        else $error("error response wrong for address");
endmodule

bind tmcr_timer tmcr_timer_asserts u_tmcr_timer_asserts (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .hold_i(hold_i),
    .ext_event_i(ext_event_i), .capture_low_i(capture_low_i),
    .capture_high_i(capture_high_i), .irq_low_o(irq_low_o),
    .irq_high_o(irq_high_o));

/* File: verif/tb_timer0_match_capture_regs.sv */
// self-checking bench for the timer register block over apb
// assumes tmcr_timer and its bound checker; events are driven as pulses
`timescale 1ns/100ps
`include "tmcr_timer_regs.vh"

module tb_timer0_match_capture_regs;
    typedef struct packed {
        logic w;
        logic [3:0] off;
        logic [7:0] d;
        logic [7:0] x;
        logic err;
    } tmcr_row_t;
    // register offsets from the control register
    localparam [3:0] ctl = 0, pre = 1, cnl = 2, cnh = 3, ml = 4, mh = 5;
    localparam [3:0] cpl = 6, cph = 7, bad = 8;
    logic clk_i = 1'b0, resetn_i = 1'b0; // clock and reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // bus request
    logic [`TMCR_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, e, irq_low, irq_high;
    logic ev = 1'b0, cap_l = 1'b0, cap_h = 1'b0, hold = 1'b0; // events
    int n_mismatch = 0, check_count = 0, cyc = 0, a, b, c, d;
    tmcr_row_t rows [0:20];

    tmcr_timer u_tmcr_timer (.clk_i(clk_i), .resetn_i(resetn_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
        .hold_i(hold), .ext_event_i(ev), .capture_low_i(cap_l),
        .capture_high_i(cap_h), .irq_low_o(irq_low), .irq_high_o(irq_high));

    // 200 mhz clock and a cycle count for period figures
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cyc <= cyc + 1;

    task report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task check(input [31:0] seen, input [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
            n_mismatch++;
        end
    endtask

    // one apb transfer: setup, then access until pready
    task xfer(input w, input [3:0] off, input [7:0] dt, output [31:0] r,
              output er);
        int n;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {`TMCR_IDX_TIMER_CONTROL + {12'h0, off}, 2'b00};
        pwdata <= {24'h0, dt};
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            report_and_stop;
        end
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input [3:0] off, input [7:0] dt);
        xfer(1'b1, off, dt, rd, e);
    endtask

    task rdc(input [3:0] off, input [7:0] x);
        xfer(1'b0, off, 8'h00, rd, e);
        check(rd, {24'h0, x});
    endtask

    // single-cycle pulses: {capture high, capture low, event}
    task pulse(input [2:0] m);
        @(posedge clk_i);
        {cap_h, cap_l, ev} <= m;
        @(posedge clk_i);
        {cap_h, cap_l, ev} <= 3'b000;
    endtask

    // clear flags by a control write, then time the next request
    task rise(input hi, input [7:0] cv, output int t);
        int n;
        wr(ctl, cv);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while ((hi ? irq_high : irq_low) !== 1'b1 && n < 300);
        if ((hi ? irq_high : irq_low) !== 1'b1) begin
            n_mismatch++;
            report_and_stop;
        end
        t = cyc;
    endtask

    initial begin
        rows = '{'{0, ctl, 0, 0, 0}, '{0, pre, 0, 0, 0}, '{0, cnl, 0, 0, 0},
            '{0, cnh, 0, 0, 0}, '{0, ml, 0, 0, 0}, '{0, mh, 0, 0, 0},
            '{0, cpl, 0, 0, 0}, '{0, cph, 0, 0, 0}, '{1, ml, 8'h5a, 0, 0},
            '{0, ml, 0, 8'h5a, 0}, '{1, mh, 8'ha5, 0, 0},
            '{0, mh, 0, 8'ha5, 0}, '{1, cnl, 8'hff, 0, 0},
            '{0, cnl, 0, 0, 0}, '{1, cnh, 8'hff, 0, 0},
            '{0, cnh, 0, 0, 0}, '{1, cpl, 8'h33, 0, 0},
            '{0, cpl, 0, 0, 0}, '{0, bad, 0, 0, 1},
            '{1, ctl, 8'h0a, 0, 0}, '{0, ctl, 0, 0, 0}};
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        // reset values, access kinds, unmapped place
        for (int i = 0; i < 21; i++) begin
            xfer(rows[i].w, rows[i].off, rows[i].d, rd, e);
            if (!rows[i].w) begin
                check(rd, {24'h0, rows[i].x});
                check({31'h0, e}, {31'h0, rows[i].err});
            end
        end
        // low byte on the prescaler: period and buffer reload
        wr(pre, 8'h03);
        wr(ml, 8'h03);
        rise(1'b0, 8'h41, a);
        rise(1'b0, 8'h41, b);
        check(b - a, 16);
        wr(ml, 8'h01);
        rise(1'b0, 8'h41, c);
        check(c - b, 16);
        rise(1'b0, 8'h41, d);
        check(d - c, 8);
        check({31'h0, irq_high}, 0);
        wr(ctl, 8'h00);
        rdc(cnl, 8'h00);
        check({31'h0, irq_low}, 0);
        // low byte on external events with capture
        wr(ml, 8'hff);
        wr(ctl, 8'h50);
        repeat (5) pulse(3'b001);
        rdc(cnl, 8'h05);
        pulse(3'b010);
        rdc(cpl, 8'h05);
        // 16-bit counter on events
        wr(ctl, 8'h00);
        wr(ml, 8'h01);
        wr(mh, 8'h01);
        wr(ctl, 8'hf5);
        repeat (256) pulse(3'b001);
        rdc(cnl, 8'h00);
        rdc(cnh, 8'h01);
        pulse(3'b100);
        rdc(cpl, 8'h00);
        rdc(cph, 8'h01);
        pulse(3'b001);
        pulse(3'b010);
        rdc(cpl, 8'h00);
        check({30'h0, irq_high, irq_low}, 0);
        pulse(3'b001);
        rdc(ctl, 8'hff);
        rdc(cnl, 8'h00);
        check({30'h0, irq_high, irq_low}, 3);
        // high byte alone on the prescaler
        wr(ctl, 8'h00);
        rise(1'b1, 8'h84, a);
        rise(1'b1, 8'h84, b);
        check(b - a, 8);
        check({31'h0, irq_low}, 0);
        // prescaler writes every third edge keep it short of its match
        wr(ctl, 8'h00);
        wr(ml, 8'hff);
        wr(pre, 8'h07);
        wr(ctl, 8'h40);
        repeat (4) wr(pre, 8'h07);
        rdc(cnl, 8'h00);
        // hold freezes the prescaler; first tick one edge after release
        hold <= 1'b1;
        wr(pre, 8'h00);
        repeat (10) @(posedge clk_i);
        rdc(cnl, 8'h00);
        hold <= 1'b0;
        rdc(cnl, 8'h01);
        // reset in mid-run: registers back to their reset values
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            xfer(1'b0, rows[i].off, 8'h00, rd, e);
            check(rd, {24'h0, rows[i].x});
        end
        check({30'h0, irq_high, irq_low}, 0);
        report_and_stop;
    end
endmodule
